// File: rtl/ddi_pkg.sv
// Shared constants and types for the DRAM data interface
package ddi_pkg;
  localparam int DQ_W = 8;
  localparam int NIB_W = 4;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int COL_W = 3;
  localparam int RANKS = 2;
  localparam int BANKS = 8;
  localparam int IDX_W = 8;
  localparam int BC_BIT = 12;
  localparam int AP_BIT = 10;
  localparam int BUF_DEPTH = 2;
  // Command codes as {ras_b, cas_b, we_b}
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  // Burst lengths in beats
  localparam logic [3:0] BL8 = 4'h8;
  localparam logic [3:0] BL4 = 4'h4;
  // Read latency in link clock rising edges
  localparam logic [3:0] RD_LAT_CK = 4'h5;
  localparam logic [3:0] LAT_LAST = 4'h1;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_OUT} ddi_rd_e;
  // Link-side pins and configuration straps, all sampled together
  typedef struct packed {
    logic ck;
    logic ck_b;
    logic [RANKS-1:0] cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq;
    logic dm;
    logic dqs;
    logic dqs_b;
    logic x8;
    logic tdqs_en;
    logic otf;
    logic bc4;
    logic ilv;
  } ddi_pins_s;
endpackage : ddi_pkg

// File: rtl/ddi_buf_if.sv
// Valid/ready carrier between the read path and its buffer
`timescale 1ns/10ps
interface ddi_buf_if #(
  parameter int W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );
  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface : ddi_buf_if

// File: rtl/ddi_fifo2.sv
// Small valid/ready buffer held in flip-flops
`timescale 1ns/10ps
module ddi_fifo2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Buffer ports
  ddi_buf_if.store b
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  assign b.in_ready = (cnt_r != CNT_FULL);
  assign b.out_valid = (cnt_r != '0);
  assign b.out_data = mem_r[rd_ptr_r];
  assign push = b.in_valid & b.in_ready;
  assign pop = b.out_ready & b.out_valid;

  // Storage
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= b.in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + CNT_ONE;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - CNT_ONE;
      end
    end
  end
endmodule : ddi_fifo2

// File: rtl/ddi_dram_if.sv
// Device side of a dual-rank DDR3 data and access interface
//
// Contract
// - Bidirectional data bus, four bits in x4 and eight bits in x8.
// - Reads drive the strobe pair with edges aligned to data changes.
// - x8 with termination strobe on disables masking, pair gives termination.
// - Spare balls idle in x4; in x8 carry upper bits, and the complement ball copies the termination strobe when it is on.
// - Two data words move on the pins per link clock cycle.
// - Each access is eight words, or four when chopped, one per half link clock cycle.
// - Bursts start at chosen column, run programmed length and order.
// - Activate uses bank and address inputs to open bank and row.
// - Read or write uses select, bank, address for rank, bank, column.
// - Two independent ranks of eight banks, each with its select.
// - Command and address sampled when true clock rises, complement falls.
// - A rank ignores any command while its select is high.
// - On-the-fly chop: address bit twelve high gives eight, low four.
// - Write beats sampled with mask high are not stored.
`timescale 1ns/10ps
module ddi_dram_if (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Configuration straps
  input wire logic i_x8_mode,
  input wire logic i_tdqs_en,
  input wire logic i_bc_otf_en,
  input wire logic i_bc4_fixed,
  input wire logic i_interleave,
  // Link clock and command pins
  input wire logic i_ck,
  input wire logic i_ck_b,
  input wire logic [1:0] i_cs_b,
  input wire logic i_ras_b,
  input wire logic i_cas_b,
  input wire logic i_we_b,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_addr,
  // Data pins
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic [7:0] o_dq_oe,
  input wire logic i_dm,
  // Strobe pins
  input wire logic i_dqs,
  input wire logic i_dqs_b,
  output logic o_dqs,
  output logic o_dqs_b,
  output logic o_dqs_oe,
  // Termination strobe; the complement is the narrow-mode unused ball
  output logic o_tdqs_term,
  output logic o_tdqs_term_cmp,
  // Status
  output logic o_rd_busy,
  output logic o_wr_busy,
  output logic [15:0] o_open_banks
);
  ddi_pkg::ddi_pins_s pin_in;
  ddi_pkg::ddi_pins_s s1_r;
  ddi_pkg::ddi_pins_s s2_r;
  logic ck_lvl;
  logic ck_prev_r;
  logic ck_rise;
  logic ck_fall;
  logic dqs_lvl;
  logic dqs_prev_r;
  logic dqs_edge;
  logic [2:0] cmd;
  logic [1:0] hit;
  logic acc_rank;
  logic [3:0] acc_bank;
  logic acc_ok;
  logic acc_bl8;
  logic idle;
  logic rd_go;
  logic wr_go;
  logic [15:0] open_r;
  logic [15:0] row0_r;
  logic [ddi_pkg::DQ_W-1:0] mem_r [2**ddi_pkg::IDX_W];
  ddi_pkg::ddi_rd_e rd_st_r;
  logic [3:0] rd_lat_r;
  logic rd_bl8_r;
  logic [4:0] rd_base_r;
  logic [2:0] rd_col_r;
  logic [3:0] fetch_cnt_r;
  logic [3:0] beat_r;
  logic [3:0] rd_len;
  logic rd_first;
  logic rd_next;
  logic rd_end;
  logic [ddi_pkg::DQ_W-1:0] dq_out_r;
  logic dqs_out_r;
  logic oe_r;
  logic wr_act_r;
  logic wr_bl8_r;
  logic [4:0] wr_base_r;
  logic [2:0] wr_col_r;
  logic [3:0] wr_cnt_r;
  logic [3:0] wr_len;
  logic term_on;
  logic wr_masked;
  logic [ddi_pkg::DQ_W-1:0] wr_word;

  ddi_buf_if #(.W(ddi_pkg::DQ_W)) rbuf ();

  // Burst address order within an eight-column block
  function automatic logic [2:0] seq_col(
    input logic [2:0] c,
    input logic [3:0] i,
    input logic bl8,
    input logic ilv
  );
    logic [2:0] k;
    k = i[2:0];
    if (ilv) begin
      seq_col = c ^ k;
    end else if (bl8) begin
      seq_col = c + k;
    end else begin
      seq_col = {c[2], c[1:0] + k[1:0]};
    end
  endfunction : seq_col

  // Pin gathering
  always_comb begin
    pin_in.ck = i_ck;
    pin_in.ck_b = i_ck_b;
    pin_in.cs_b = i_cs_b;
    pin_in.ras_b = i_ras_b;
    pin_in.cas_b = i_cas_b;
    pin_in.we_b = i_we_b;
    pin_in.ba = i_ba;
    pin_in.addr = i_addr;
    pin_in.dq = i_dq;
    pin_in.dm = i_dm;
    pin_in.dqs = i_dqs;
    pin_in.dqs_b = i_dqs_b;
    pin_in.x8 = i_x8_mode;
    pin_in.tdqs_en = i_tdqs_en;
    pin_in.otf = i_bc_otf_en;
    pin_in.bc4 = i_bc4_fixed;
    pin_in.ilv = i_interleave;
  end

  // Two-stage synchroniser for every pin
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
    end
  end

  // Differential crossings of link clock and strobe
  assign ck_lvl = s2_r.ck & ~s2_r.ck_b;
  assign dqs_lvl = s2_r.dqs & ~s2_r.dqs_b;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ck_prev_r <= 1'b0;
      dqs_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= ck_lvl;
      dqs_prev_r <= dqs_lvl;
    end
  end

  assign ck_rise = ck_lvl & ~ck_prev_r;
  assign ck_fall = ~ck_lvl & ck_prev_r;
  assign dqs_edge = (dqs_lvl ^ dqs_prev_r) & wr_act_r;

  // Command decode
  assign cmd = {s2_r.ras_b, s2_r.cas_b, s2_r.we_b};
  assign hit = ~s2_r.cs_b;
  assign acc_rank = ~hit[0];
  assign acc_bank = {acc_rank, s2_r.ba};
  assign acc_ok = (|hit) & open_r[acc_bank];
  assign acc_bl8 = s2_r.otf ? s2_r.addr[ddi_pkg::BC_BIT] : ~s2_r.bc4;
  assign idle = (rd_st_r == ddi_pkg::RD_IDLE) & ~wr_act_r;
  assign rd_go = ck_rise & (cmd == ddi_pkg::CMD_RD) & acc_ok & idle;
  assign wr_go = ck_rise & (cmd == ddi_pkg::CMD_WR) & acc_ok & idle;

  // Bank open state per rank
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      open_r <= '0;
      row0_r <= '0;
    end else if (ck_rise) begin
      for (int r = 0; r < ddi_pkg::RANKS; r++) begin
        if (hit[r] && cmd == ddi_pkg::CMD_ACT) begin
          open_r[{1'(r), s2_r.ba}] <= 1'b1;
          row0_r[{1'(r), s2_r.ba}] <= s2_r.addr[0];
        end else if (hit[r] && cmd == ddi_pkg::CMD_PRE) begin
          if (s2_r.addr[ddi_pkg::AP_BIT]) begin
            open_r[r*ddi_pkg::BANKS +: ddi_pkg::BANKS] <= '0;
          end else begin
            open_r[{1'(r), s2_r.ba}] <= 1'b0;
          end
        end
      end
    end
  end

  // Read control
  assign rd_len = rd_bl8_r ? ddi_pkg::BL8 : ddi_pkg::BL4;
  assign rd_first = (rd_st_r == ddi_pkg::RD_WAIT) & ck_rise
      & (rd_lat_r == ddi_pkg::LAT_LAST);
  assign rd_next = (rd_st_r == ddi_pkg::RD_OUT) & (ck_rise | ck_fall)
      & (beat_r != rd_len);
  assign rd_end = (rd_st_r == ddi_pkg::RD_OUT) & (ck_rise | ck_fall)
      & (beat_r == rd_len);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_st_r <= ddi_pkg::RD_IDLE;
      rd_lat_r <= ddi_pkg::CNT_ZERO;
      rd_bl8_r <= 1'b0;
      rd_base_r <= '0;
      rd_col_r <= '0;
    end else begin
      unique case (rd_st_r)
        ddi_pkg::RD_IDLE: begin
          if (rd_go) begin
            rd_st_r <= ddi_pkg::RD_WAIT;
            rd_lat_r <= ddi_pkg::RD_LAT_CK;
            rd_bl8_r <= acc_bl8;
            rd_base_r <= {acc_bank, row0_r[acc_bank]};
            rd_col_r <= s2_r.addr[ddi_pkg::COL_W-1:0];
          end
        end
        ddi_pkg::RD_WAIT: begin
          if (rd_first) begin
            rd_st_r <= ddi_pkg::RD_OUT;
          end else if (ck_rise) begin
            rd_lat_r <= rd_lat_r - ddi_pkg::CNT_ONE;
          end
        end
        ddi_pkg::RD_OUT: begin
          if (rd_end) begin
            rd_st_r <= ddi_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  // Core fetch into the buffer, stalled when it is full
  assign rbuf.in_valid = (rd_st_r != ddi_pkg::RD_IDLE)
      & (fetch_cnt_r != rd_len);
  assign rbuf.in_data = mem_r[{rd_base_r,
      seq_col(rd_col_r, fetch_cnt_r, rd_bl8_r, s2_r.ilv)}];
  assign rbuf.out_ready = rd_first | rd_next;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fetch_cnt_r <= ddi_pkg::CNT_ZERO;
    end else if (rd_go) begin
      fetch_cnt_r <= ddi_pkg::CNT_ZERO;
    end else if (rbuf.in_valid & rbuf.in_ready) begin
      fetch_cnt_r <= fetch_cnt_r + ddi_pkg::CNT_ONE;
    end
  end

  ddi_fifo2 #(
    .W(ddi_pkg::DQ_W),
    .DEPTH(ddi_pkg::BUF_DEPTH)
  ) u_rbuf (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .b(rbuf.store)
  );

  // Read beat driver: word and strobe edge change together
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dq_out_r <= '0;
      dqs_out_r <= 1'b0;
      oe_r <= 1'b0;
      beat_r <= ddi_pkg::CNT_ZERO;
    end else if (rd_go) begin
      beat_r <= ddi_pkg::CNT_ZERO;
    end else if (rd_first | rd_next) begin
      if (rbuf.out_valid) begin
        dq_out_r <= rbuf.out_data;
      end
      dqs_out_r <= rd_first ? 1'b1 : ~dqs_out_r;
      oe_r <= 1'b1;
      beat_r <= beat_r + ddi_pkg::CNT_ONE;
    end else if (rd_end) begin
      oe_r <= 1'b0;
      dqs_out_r <= 1'b0;
    end
  end

  assign o_dq = s2_r.x8 ? dq_out_r
      : {{ddi_pkg::NIB_W{1'b0}}, dq_out_r[ddi_pkg::NIB_W-1:0]};
  assign o_dq_oe = {{ddi_pkg::NIB_W{oe_r & s2_r.x8}},
      {ddi_pkg::NIB_W{oe_r}}};
  assign o_dqs = dqs_out_r;
  assign o_dqs_b = ~dqs_out_r;
  assign o_dqs_oe = oe_r;

  // Termination strobe and mask
  assign term_on = s2_r.x8 & s2_r.tdqs_en;
  assign o_tdqs_term = term_on;
  assign o_tdqs_term_cmp = term_on;
  assign wr_masked = s2_r.dm & ~term_on;
  assign wr_word = s2_r.x8 ? s2_r.dq
      : {{ddi_pkg::NIB_W{1'b0}}, s2_r.dq[ddi_pkg::NIB_W-1:0]};

  // Write control
  assign wr_len = wr_bl8_r ? ddi_pkg::BL8 : ddi_pkg::BL4;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_act_r <= 1'b0;
      wr_bl8_r <= 1'b0;
      wr_base_r <= '0;
      wr_col_r <= '0;
      wr_cnt_r <= ddi_pkg::CNT_ZERO;
    end else if (wr_go) begin
      wr_act_r <= 1'b1;
      wr_bl8_r <= acc_bl8;
      wr_base_r <= {acc_bank, row0_r[acc_bank]};
      wr_col_r <= s2_r.addr[ddi_pkg::COL_W-1:0];
      wr_cnt_r <= ddi_pkg::CNT_ZERO;
    end else if (dqs_edge) begin
      wr_cnt_r <= wr_cnt_r + ddi_pkg::CNT_ONE;
      if (wr_cnt_r + ddi_pkg::CNT_ONE == wr_len) begin
        wr_act_r <= 1'b0;
      end
    end
  end

  // Array write, one beat per strobe edge
  always_ff @(posedge i_ref_clk) begin
    if (dqs_edge & ~wr_masked) begin
      mem_r[{wr_base_r,
          seq_col(wr_col_r, wr_cnt_r, wr_bl8_r, s2_r.ilv)}] <= wr_word;
    end
  end

  // Status
  assign o_rd_busy = (rd_st_r != ddi_pkg::RD_IDLE);
  assign o_wr_busy = wr_act_r;
  assign o_open_banks = open_r;
endmodule : ddi_dram_if

// File: testbench/ddi_props.sv
// Port checker for the DRAM data interface
`timescale 1ns/10ps
module ddi_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Inputs
  input wire logic i_x8_mode,
  input wire logic [1:0] i_cs_b,
  // Outputs
  input wire logic [7:0] o_dq_oe,
  input wire logic o_dqs,
  input wire logic o_dqs_b,
  input wire logic o_dqs_oe,
  input wire logic o_tdqs_term,
  input wire logic o_tdqs_term_cmp,
  input wire logic o_rd_busy,
  input wire logic o_wr_busy,
  input wire logic [15:0] o_open_banks
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic [5:0] oe_cnt_r;
  // Cycles the strobe has been driven
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      oe_cnt_r <= 6'h0;
    else if (!o_dqs_oe)
      oe_cnt_r <= 6'h0;
    else
      oe_cnt_r <= oe_cnt_r + 6'h1;
  end
  sequence s_desel;
    (i_cs_b == 2'h3) [*8];
  endsequence
  sequence s_narrow;
    (!i_x8_mode) [*5];
  endsequence
  sequence s_beat;
    $changed(o_dqs) && o_dqs_oe && $past(o_dqs_oe);
  endsequence
  chk_strobe_compl: assert property (o_dqs_b == ~o_dqs)
    else $error("strobe pair not complementary");
  chk_term_pair: assert property (o_tdqs_term_cmp == o_tdqs_term)
    else $error("termination pair differs");
  chk_narrow_term: assert property (s_narrow |-> !o_tdqs_term)
    else $error("termination in narrow mode");
  chk_narrow_oe: assert property (s_narrow |-> o_dq_oe[7:4] == 4'h0)
    else $error("upper data driven in narrow mode");
  chk_oe_pair: assert property (o_dqs_oe == (o_dq_oe[3:0] == 4'hf))
    else $error("data and strobe enables differ");
  chk_oe_in_read: assert property (o_dqs_oe |-> o_rd_busy)
    else $error("strobe driven outside read");
  chk_rw_excl: assert property (!(o_wr_busy && o_dqs_oe))
    else $error("read output during write");
  chk_desel_hold: assert property (s_desel |=> $stable(o_open_banks))
    else $error("bank state moved while deselected");
  chk_beat_hold: assert property (s_beat |=> $stable(o_dqs) [*3])
    else $error("read beat shorter than half link clock");
  chk_burst_len: assert property (oe_cnt_r < 6'h22)
    else $error("read burst longer than eight beats");
endmodule : ddi_props

bind ddi_dram_if ddi_props i_ddi_props (.i_ref_clk, .i_rst_b, .i_x8_mode,
  .i_cs_b, .o_dq_oe, .o_dqs, .o_dqs_b, .o_dqs_oe, .o_tdqs_term,
  .o_tdqs_term_cmp, .o_rd_busy, .o_wr_busy, .o_open_banks);

// File: testbench/ddi_mc.sv
// Controller model driving command, strobe and data pins
`timescale 1ns/10ps
module ddi_mc (
  // Clock
  input wire logic i_ref_clk,
  // Resolved data and strobe wires
  input wire logic [7:0] i_rd_dq,
  input wire logic i_rd_dqs,
  input wire logic i_rd_dqs_oe,
  // Pins to device
  output logic o_ck,
  output logic [1:0] o_cs_b,
  output logic [2:0] o_cmd,
  output logic [2:0] o_ba,
  output logic [13:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dm,
  output logic o_dqs
);
  logic [1:0] ph = 2'h0;
  initial begin
    o_ck = 1'b0;
    o_cs_b = 2'h3;
    o_cmd = 3'h7;
    o_ba = 3'h0;
    o_addr = 14'h0;
    o_dq = 8'h0;
    o_dm = 1'b0;
    o_dqs = 1'b0;
  end
  // Free-running link clock, eight ref cycles
  always @(negedge i_ref_clk) begin
    ph <= ph + 2'h1;
    if (ph == 2'h3)
      o_ck <= ~o_ck;
  end
  // Command held across one link clock rise
  task automatic cmd(input logic [1:0] cs, input logic [2:0] c,
    input logic [2:0] b, input logic [13:0] a);
    @(negedge o_ck);
    o_cs_b = cs;
    o_cmd = c;
    o_ba = b;
    o_addr = a;
    @(negedge o_ck);
    o_cs_b = 2'h3;
    o_cmd = ~c;
    o_ba = ~b;
    o_addr = ~a;
  endtask : cmd
  // Write burst to rank 0, strobe parks low
  task automatic wr(input logic [2:0] b, input logic [2:0] col,
    input logic bl8, input logic [63:0] d, input logic [7:0] m);
    cmd(2'h2, ddi_pkg::CMD_WR, b, {1'b0, bl8, 9'h0, col});
    for (int i = 0; i < (bl8 ? 8 : 4); i++) begin
      o_dq = d[8*i+:8];
      o_dm = m[i];
      repeat (2) @(negedge i_ref_clk);
      o_dqs = ~o_dqs;
      repeat (2) @(negedge i_ref_clk);
    end
    o_dq = ~o_dq;
    o_dm = 1'b0;
  endtask : wr
  // Read burst, one beat per strobe change
  task automatic rd(input logic [1:0] cs, input logic [2:0] b,
    input logic [2:0] col, input logic bl8, output logic [63:0] q,
    output int got);
    logic prev;
    prev = 1'b0;
    got = 0;
    q = 64'h0;
    cmd(cs, ddi_pkg::CMD_RD, b, {1'b0, bl8, 9'h0, col});
    for (int k = 0; k < 120 && got < 8; k++) begin
      @(negedge i_ref_clk);
      if (i_rd_dqs_oe === 1'b1 && i_rd_dqs !== prev) begin
        q[8*got+:8] = i_rd_dq;
        got++;
      end
      prev = i_rd_dqs;
    end
  endtask : rd
endmodule : ddi_mc

// File: testbench/tb_ddi_dram_if.sv
// Self-checking bench for the DRAM data interface
`timescale 1ns/10ps
module tb_ddi_dram_if;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic x8 = 1'b1;
  logic tdqs = 1'b0;
  logic otf = 1'b1;
  logic bc4 = 1'b0;
  logic ilv = 1'b0;
  logic ck, dm, dqs, dqs_o, dqs_b_o, dqs_oe, term, term_c, rbusy, wbusy;
  logic [1:0] cs_b;
  logic [2:0] cmd, ba;
  logic [13:0] addr;
  logic [7:0] dq, rdq, dq_oe;
  logic [15:0] banks;
  logic [7:0] mem [8];
  logic [63:0] q;
  int got;
  int failures = 0;
  int n_checks = 0;
  wire [7:0] dq_w = (dq_oe & rdq) | (~dq_oe & dq);
  wire dqs_w = dqs_oe ? dqs_o : dqs;
  always #25 i_ref_clk = ~i_ref_clk;
  ddi_mc i_ddi_mc (.i_ref_clk, .i_rd_dq(dq_w), .i_rd_dqs(dqs_w),
    .i_rd_dqs_oe(dqs_oe), .o_ck(ck), .o_cs_b(cs_b), .o_cmd(cmd),
    .o_ba(ba), .o_addr(addr), .o_dq(dq), .o_dm(dm), .o_dqs(dqs));
  ddi_dram_if i_ddi_dram_if (.i_ref_clk, .i_rst_b, .i_x8_mode(x8),
    .i_tdqs_en(tdqs), .i_bc_otf_en(otf), .i_bc4_fixed(bc4),
    .i_interleave(ilv), .i_ck(ck), .i_ck_b(~ck), .i_cs_b(cs_b),
    .i_ras_b(cmd[2]), .i_cas_b(cmd[1]), .i_we_b(cmd[0]), .i_ba(ba),
    .i_addr(addr), .i_dq(dq_w), .o_dq(rdq), .o_dq_oe(dq_oe), .i_dm(dm),
    .i_dqs(dqs_w), .i_dqs_b(~dqs_w), .o_dqs(dqs_o), .o_dqs_b(dqs_b_o),
    .o_dqs_oe(dqs_oe), .o_tdqs_term(term), .o_tdqs_term_cmp(term_c),
    .o_rd_busy(rbusy), .o_wr_busy(wbusy), .o_open_banks(banks));
  function automatic logic [2:0] col_at(input logic [2:0] c,
    input logic [2:0] i, input logic bl8, input logic il);
    if (il)
      return c ^ i;
    if (bl8)
      return c + i;
    return {c[2], c[1:0] + i[1:0]};
  endfunction : col_at
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic nap(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : nap
  task automatic idle;
    int k;
    k = 0;
    while ((rbusy !== 1'b0 || wbusy !== 1'b0) && k < 300) begin
      @(negedge i_ref_clk);
      k++;
    end
    if (k == 300) begin
      failures++;
      $display("Error busy expected 0 seen 1");
      print_verdict();
    end
  endtask : idle
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Read rank 0 bank 3 and compare each beat
  task automatic rdchk(input logic [2:0] col, input logic a12,
    input logic bl8, input int n);
    i_ddi_mc.rd(2'h2, 3'h3, col, a12, q, got);
    chk("beats", 16'(n), 16'(got));
    for (int i = 0; i < n; i++) begin
      chk("rdata", {8'h0, mem[col_at(col, 3'(i), bl8, ilv)] &
        (x8 ? 8'hff : 8'h0f)},
        {8'h0, q[8*i+:8] & (x8 ? 8'hff : 8'h0f)});
    end
    idle();
  endtask : rdchk
  task automatic t_reset;
    chk("open", 16'h0, banks);
    chk("strobe", 16'h2, {14'h0, dqs_b_o, dqs_oe});
    chk("oe", 16'h0, {8'h0, dq_oe});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_banks;
    i_ddi_mc.cmd(2'h2, ddi_pkg::CMD_ACT, 3'h3, 14'h0);
    i_ddi_mc.cmd(2'h3, ddi_pkg::CMD_ACT, 3'h5, 14'h0);
    i_ddi_mc.cmd(2'h1, ddi_pkg::CMD_ACT, 3'h7, 14'h0);
    nap(4);
    chk("open", 16'h8008, banks);
    i_ddi_mc.cmd(2'h1, ddi_pkg::CMD_PRE, 3'h7, 14'h0);
    nap(4);
    chk("open", 16'h0008, banks);
    i_ddi_mc.cmd(2'h0, ddi_pkg::CMD_ACT, 3'h1, 14'h0);
    nap(4);
    chk("open", 16'h020a, banks);
    i_ddi_mc.cmd(2'h0, ddi_pkg::CMD_PRE, 3'h0, 14'h0400);
    nap(4);
    chk("open", 16'h0000, banks);
    i_ddi_mc.cmd(2'h2, ddi_pkg::CMD_ACT, 3'h3, 14'h0);
    nap(4);
    chk("open", 16'h0008, banks);
    $display("t_banks done");
  endtask : t_banks
  task automatic t_rdwr;
    i_ddi_mc.wr(3'h3, 3'h0, 1'b1, 64'ha7a6a5a4a3a2a1a0, 8'h0);
    idle();
    i_ddi_mc.wr(3'h3, 3'h2, 1'b1, 64'hc7c6c5c4c3c2c1c0, 8'h2);
    idle();
    for (int i = 0; i < 8; i++) begin
      mem[i] = 8'ha0 + 8'(i);
    end
    for (int i = 0; i < 8; i++) begin
      if (i != 1)
        mem[3'(i + 2)] = 8'hc0 + 8'(i);
    end
    rdchk(3'h5, 1'b1, 1'b1, 8);
    ilv = 1'b1;
    rdchk(3'h6, 1'b0, 1'b0, 4);
    ilv = 1'b0;
    otf = 1'b0;
    rdchk(3'h2, 1'b0, 1'b1, 8);
    bc4 = 1'b1;
    rdchk(3'h2, 1'b1, 1'b0, 4);
    otf = 1'b1;
    bc4 = 1'b0;
    i_ddi_mc.rd(2'h1, 3'h3, 3'h0, 1'b1, q, got);
    chk("beats", 16'h0, 16'(got));
    $display("t_rdwr done");
  endtask : t_rdwr
  task automatic t_narrow;
    tdqs = 1'b1;
    nap(6);
    chk("term", 16'h3, {14'h0, term, term_c});
    i_ddi_mc.wr(3'h3, 3'h0, 1'b0, 64'h5d5c5b5a, 8'hff);
    idle();
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'h5a + 8'(i);
    end
    rdchk(3'h0, 1'b0, 1'b0, 4);
    x8 = 1'b0;
    nap(6);
    chk("term", 16'h0, {14'h0, term, term_c});
    rdchk(3'h0, 1'b0, 1'b0, 4);
    chk("dq_hi", 16'h0, {12'h0, rdq[7:4]});
    $display("t_narrow done");
  endtask : t_narrow
  initial begin
    repeat (12) @(negedge i_ref_clk);
    t_reset();
    i_rst_b = 1'b1;
    nap(4);
    t_banks();
    t_rdwr();
    t_narrow();
    print_verdict();
  end
endmodule : tb_ddi_dram_if
